/* File: rtl/smrc_pkg.sv */
/*
 * Shared constants and types for the two-wire register client.
 * Assumes a single 10 MHz core clock; all bus timing is derived from it.
 */
package smrc_pkg;

   // Core clock rate
   localparam int CLK_HZ      = 10_000_000;

   // Clock-low timeout, 30 ms
   localparam int LOW_TO_MS   = 30;
   localparam int LOW_TO_CYC  = LOW_TO_MS * (CLK_HZ / 1000);

   // Bus-idle timeout, 150 us
   localparam int IDLE_TO_US  = 150;
   localparam int IDLE_TO_CYC = IDLE_TO_US * (CLK_HZ / 1_000_000);

   // Addressing
   localparam logic [6:0] ARA_ADDR        = 7'h0C;
   localparam logic [6:0] CLIENT_ADDR_DEF = 7'h2E;
   localparam logic       RW_READ         = 1'b1;
   localparam logic       ARA_LSB         = 1'b0;

   // Byte framing and pointer
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] BIT_ZERO  = 4'h0;
   localparam logic [3:0] BIT_STEP  = 4'h1;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] PTR_STEP  = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // Protocol states
   typedef enum logic [2:0] {
      S_IDLE    = 3'b000,
      S_RECV    = 3'b001,
      S_ACK_OUT = 3'b010,
      S_SEND    = 3'b011,
      S_ACK_IN  = 3'b100
   } smrc_state_t;

   // Meaning of the byte being received
   typedef enum logic [1:0] {
      K_ADDR = 2'b00,
      K_PTR  = 2'b01,
      K_DATA = 2'b10
   } smrc_kind_t;

endpackage

/* File: rtl/smrc_client.sv */
/*
 * Two-wire (SMBus/I2C) register client with pointer, timeouts and alert
 * response. Assumes the register file sits outside on the same clock:
 * reads are combinational on regRdAddr, writes leave through a two-entry
 * buffer. The pin wire is resolved outside from sdaOe.
 */
//
// Contract
// - Clock low over 30 ms resets protocol.
// - Both lines high over 150 us reset.
// - Block transfers carry no byte count.
// - Six transaction types are accepted.
// - Write byte: address, pointer, data, all acknowledged; data is nacked while the write buffer is full.
// - Pointer steps on each acknowledged written byte.
// - Read byte: pointer write, repeated start, read.
// - Host ack steps pointer, next register follows.
// - Pointer wraps FFh to 00h unchecked.
// - Send byte only loads the pointer.
// - Receive byte returns register at pointer.
// - Alert response returns own client address.
// - Alert reply counts only if fully sent.
// - Delivered alert reply sets mask bit.
// - Acknowledge data, own address, alert address; data only with buffer room, alert address only if alertPending.
// - Bytes are eight bits, MSB first.
// - Stop returns interface to ready.
// - Clock-low timeout off until enabled.
`timescale 1ns/10ps
`default_nettype none

module smrc_client
   import smrc_pkg::*;
#(
   parameter logic [6:0] CLIENT_ADDR   = CLIENT_ADDR_DEF,
   parameter int         LOW_TO_CYCLES = LOW_TO_CYC
) (
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   input  wire logic       timeoutDisable,
   input  wire logic       alertPending,
   output logic [7:0]      regRdAddr,
   input  wire logic [7:0] regRdData,
   output logic            wrValid,
   output logic [7:0]      wrAddr,
   output logic [7:0]      wrData,
   input  wire logic       wrReady,
   output logic            alertMaskSet
);

   localparam int LOW_W  = $clog2(LOW_TO_CYCLES + 1);
   localparam int IDLE_W = $clog2(IDLE_TO_CYC + 1);

   // Elaboration check on the timeout length
   if (LOW_TO_CYCLES < 2) begin : g_bad_low
      $error("LOW_TO_CYCLES must be at least 2");
   end

   // Pin synchronisers and edge history
   logic sclM_q, sclS_q, sclP_q;
   logic sdaM_q, sdaS_q, sdaP_q;
   always_ff @(posedge mclk) begin
      if (srst) begin
         sclM_q <= 1'b1;
         sclS_q <= 1'b1;
         sclP_q <= 1'b1;
         sdaM_q <= 1'b1;
         sdaS_q <= 1'b1;
         sdaP_q <= 1'b1;
      end else begin
         sclM_q <= sclIn;
         sclS_q <= sclM_q;
         sclP_q <= sclS_q;
         sdaM_q <= sdaIn;
         sdaS_q <= sdaM_q;
         sdaP_q <= sdaS_q;
      end
   end
   // Bus events seen on the sampled lines
   logic sclRise, sclFall, startEv, stopEv;
   assign sclRise = sclS_q & ~sclP_q;
   assign sclFall = ~sclS_q & sclP_q;
   assign startEv = sclS_q & sclP_q & sdaP_q & ~sdaS_q;
   assign stopEv  = sclS_q & sclP_q & ~sdaP_q & sdaS_q;
   // Protocol state
   smrc_state_t state_q, state_d;
   smrc_kind_t  kind_q, kind_d;
   logic [3:0]  bitCnt_q, bitCnt_d;
   logic [7:0]  shift_q, shift_d;
   logic [7:0]  ptr_q, ptr_d;
   logic        readDir_q, readDir_d;
   logic        araMode_q, araMode_d;
   logic        hostAck_q, hostAck_d;
   logic        maskSet_q, maskSet_d;
   logic        sdaOe_q, sdaOe_d;
   logic        push, busReset, bufInReady;
   // Timeout counters
   logic [LOW_W-1:0]  lowCnt_q, lowCnt_d;
   logic [IDLE_W-1:0] idleCnt_q, idleCnt_d;
   logic              lowHit, idleHit;
   assign lowHit   = lowCnt_q == LOW_W'(LOW_TO_CYCLES);
   assign idleHit  = idleCnt_q == IDLE_W'(IDLE_TO_CYC);
   assign busReset = lowHit | idleHit;

   // Clock-low count only when enabled; idle count only mid-transaction
   always_comb begin
      lowCnt_d  = '0;
      idleCnt_d = '0;
      if (!sclS_q && !timeoutDisable && !lowHit) begin
         lowCnt_d = lowCnt_q + LOW_W'(1);
      end
      if (sclS_q && sdaS_q && state_q != S_IDLE && !idleHit) begin
         idleCnt_d = idleCnt_q + IDLE_W'(1);
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         lowCnt_q  <= '0;
         idleCnt_q <= '0;
      end else begin
         lowCnt_q  <= lowCnt_d;
         idleCnt_q <= idleCnt_d;
      end
   end
   // Next protocol state
   always_comb begin
      logic ackIt;
      ackIt     = 1'b0;
      state_d   = state_q;
      kind_d    = kind_q;
      bitCnt_d  = bitCnt_q;
      shift_d   = shift_q;
      ptr_d     = ptr_q;
      readDir_d = readDir_q;
      araMode_d = araMode_q;
      hostAck_d = hostAck_q;
      sdaOe_d   = sdaOe_q;
      maskSet_d = 1'b0;
      push      = 1'b0;
      if (busReset || stopEv) begin
         state_d = S_IDLE;
         sdaOe_d = 1'b0;
      end else if (startEv) begin
         state_d   = S_RECV;
         kind_d    = K_ADDR;
         bitCnt_d  = BIT_ZERO;
         araMode_d = 1'b0;
         sdaOe_d   = 1'b0;
      end else begin
         unique case (state_q)
            S_RECV: begin
               if (sclRise && bitCnt_q != BYTE_BITS) begin
                  shift_d  = {shift_q[6:0], sdaS_q};
                  bitCnt_d = bitCnt_q + BIT_STEP;
               end else if (sclFall && bitCnt_q == BYTE_BITS) begin
                  unique case (kind_q)
                     K_ADDR: begin
                        if (shift_q[7:1] == CLIENT_ADDR) begin
                           ackIt     = 1'b1;
                           readDir_d = shift_q[0];
                        end else if (shift_q == {ARA_ADDR, RW_READ} && alertPending) begin
                           ackIt     = 1'b1;
                           readDir_d = 1'b1;
                           araMode_d = 1'b1;
                        end
                     end
                     K_PTR: begin
                        ackIt = 1'b1;
                        ptr_d = shift_q;
                     end
                     default: begin
                        if (bufInReady) begin
                           ackIt = 1'b1;
                           push  = 1'b1;
                           ptr_d = ptr_q + PTR_STEP;
                        end
                     end
                  endcase
                  state_d = ackIt ? S_ACK_OUT : S_IDLE;
                  sdaOe_d = ackIt;
               end
            end
            S_ACK_OUT: begin
               if (sclFall) begin
                  bitCnt_d = BIT_ZERO;
                  if (readDir_q) begin
                     shift_d = araMode_q ? {CLIENT_ADDR, ARA_LSB} : regRdData;
                     sdaOe_d = ~shift_d[7];
                     state_d = S_SEND;
                  end else begin
                     sdaOe_d = 1'b0;
                     state_d = S_RECV;
                     kind_d  = (kind_q == K_ADDR) ? K_PTR : K_DATA;
                  end
               end
            end
            S_SEND: begin
               if (sclRise) begin
                  if (!sdaOe_q && !sdaS_q) begin
                     state_d = S_IDLE;
                     sdaOe_d = 1'b0;
                  end else begin
                     bitCnt_d = bitCnt_q + BIT_STEP;
                  end
               end else if (sclFall) begin
                  if (bitCnt_q == BYTE_BITS) begin
                     sdaOe_d   = 1'b0;
                     hostAck_d = 1'b0;
                     state_d   = S_ACK_IN;
                     maskSet_d = araMode_q;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     sdaOe_d = ~shift_q[6];
                  end
               end
            end
            S_ACK_IN: begin
               if (sclRise) begin
                  hostAck_d = ~sdaS_q;
                  if (!sdaS_q && !araMode_q) begin
                     ptr_d = ptr_q + PTR_STEP;
                  end
               end else if (sclFall) begin
                  if (hostAck_q && !araMode_q) begin
                     shift_d  = regRdData;
                     sdaOe_d  = ~regRdData[7];
                     bitCnt_d = BIT_ZERO;
                     state_d  = S_SEND;
                  end else begin
                     state_d = S_IDLE;
                  end
               end
            end
            default: begin  // Idle waits for start; unused codes recover
               state_d = S_IDLE;
               sdaOe_d = 1'b0;
            end
         endcase
      end
   end

   // Protocol registers; pointer survives stop and timeouts
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_q   <= S_IDLE;
         kind_q    <= K_ADDR;
         bitCnt_q  <= BIT_ZERO;
         shift_q   <= BYTE_ZERO;
         ptr_q     <= PTR_RESET;
         readDir_q <= 1'b0;
         araMode_q <= 1'b0;
         hostAck_q <= 1'b0;
         maskSet_q <= 1'b0;
         sdaOe_q   <= 1'b0;
      end else begin
         state_q   <= state_d;
         kind_q    <= kind_d;
         bitCnt_q  <= bitCnt_d;
         shift_q   <= shift_d;
         ptr_q     <= ptr_d;
         readDir_q <= readDir_d;
         araMode_q <= araMode_d;
         hostAck_q <= hostAck_d;
         maskSet_q <= maskSet_d;
         sdaOe_q   <= sdaOe_d;
      end
   end

   // Two-entry write buffer: output stage plus spare
   logic       ov_q, ov_d, sv_q, sv_d;
   logic [7:0] oa_q, oa_d, od_q, od_d, sa_q, sa_d, sd_q, sd_d;
   logic       pop;
   assign bufInReady = ~sv_q;
   assign pop        = ov_q & wrReady;
   always_comb begin
      ov_d = ov_q;
      oa_d = oa_q;
      od_d = od_q;
      sv_d = sv_q;
      sa_d = sa_q;
      sd_d = sd_q;
      if (pop) begin
         ov_d = sv_q;
         oa_d = sa_q;
         od_d = sd_q;
         sv_d = 1'b0;
      end
      if (push) begin
         if (!ov_d) begin
            ov_d = 1'b1;
            oa_d = ptr_q;
            od_d = shift_q;
         end else begin
            sv_d = 1'b1;
            sa_d = ptr_q;
            sd_d = shift_q;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         ov_q <= 1'b0;
         oa_q <= BYTE_ZERO;
         od_q <= BYTE_ZERO;
         sv_q <= 1'b0;
         sa_q <= BYTE_ZERO;
         sd_q <= BYTE_ZERO;
      end else begin
         ov_q <= ov_d;
         oa_q <= oa_d;
         od_q <= od_d;
         sv_q <= sv_d;
         sa_q <= sa_d;
         sd_q <= sd_d;
      end
   end
   // Open-drain data level is always low when enabled
   logic sdaOut_q;
   always_ff @(posedge mclk) begin
      sdaOut_q <= 1'b0;
   end
   // Outputs straight from flops
   assign sdaOut       = sdaOut_q;
   assign sdaOe        = sdaOe_q;
   assign regRdAddr    = ptr_q;
   assign wrValid      = ov_q;
   assign wrAddr       = oa_q;
   assign wrData       = od_q;
   assign alertMaskSet = maskSet_q;
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   logic ackByte;
   assign ackByte = state_q == S_RECV && sclFall && bitCnt_q == BYTE_BITS && !busReset && !stopEv && !startEv;
   a_ack_own_addr: assert property (ackByte && kind_q == K_ADDR && shift_q[7:1] == CLIENT_ADDR
                                    |=> sdaOe_q && state_q == S_ACK_OUT)
      else $error("own address not acknowledged");
   a_ptr_load: assert property (ackByte && kind_q == K_PTR |=> ptr_q == $past(shift_q)
                                && (!wrValid || $past(wrValid))) else $error("pointer byte not loaded");
   a_ptr_step_wr: assert property (push |=> ptr_q == 8'($past(ptr_q) + 8'h01) && ov_q)
      else $error("write pointer did not step");
   a_low_reset: assert property (lowHit |=> state_q == S_IDLE && !sdaOe_q && lowCnt_q == '0)
      else $error("clock-low timeout did not reset");
   a_idle_reset: assert property (idleHit |=> state_q == S_IDLE)
      else $error("idle timeout did not reset");
   a_stop_idle: assert property (stopEv |=> state_q == S_IDLE ##1 !sdaOe_q)
      else $error("stop did not release interface");
   a_timeout_off: assert property (timeoutDisable |=> lowCnt_q == '0)
      else $error("clock-low count ran while disabled");
   a_mask_cause: assert property (alertMaskSet |-> araMode_q && state_q == S_ACK_IN && $past(bitCnt_q) == BYTE_BITS)
      else $error("mask set without delivered reply");
   a_rx_msb: assert property (state_q == S_RECV && sclRise && bitCnt_q != BYTE_BITS
                              && !startEv && !stopEv && !busReset |=> shift_q == {$past(shift_q[6:0]), $past(sdaS_q)})
      else $error("receive shift wrong");
   a_nack_hold: assert property (state_q == S_ACK_IN && sclRise && sdaS_q && !stopEv && !busReset |=> $stable(ptr_q))
      else $error("pointer moved on host nack");
   c_write: cover property (push ##[1:1000] push);
   c_read_ack: cover property (state_q == S_ACK_IN && hostAck_q && sclFall);
   c_ara: cover property (alertMaskSet);
   c_buf_full: cover property (sv_q && !wrReady);

endmodule

`default_nettype wire

/* File: testbench/smrc_host_model.sv */
/*
 * Host-side model of the two-wire bus: drives the clock and pulls data low.
 * Assumes the bench resolves the data wire with a pull-up and feeds sdaBus.
 */
`timescale 1ns/10ps
`default_nettype none

module smrc_host_model (
   input  wire logic mclk,
   input  wire logic sdaBus,
   output var logic  sclOut,
   output var logic  sdaLow
);
   // 800 ns bus period, four core cycles a phase
   localparam int HALF = 4;

   // Idle bus with both lines released
   initial begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // Start or repeated start, framing every transaction
   task automatic start();
      tick(HALF / 2);
      sdaLow = 1'b0;
      tick(HALF / 2);
      sclOut = 1'b1;
      tick(HALF);
      sdaLow = 1'b1;
      tick(HALF);
      sclOut = 1'b0;
   endtask

   // Stop condition ends the transfer
   task automatic stop();
      tick(HALF / 2);
      sdaLow = 1'b1;
      tick(HALF / 2);
      sclOut = 1'b1;
      tick(HALF);
      sdaLow = 1'b0;
      tick(HALF);
   endtask

   // One clock: data set mid-low, sampled at end of high
   task automatic bitIo(input logic b, input int hi, output logic r);
      tick(HALF / 2);
      sdaLow = !b;
      tick(HALF / 2);
      sclOut = 1'b1;
      tick(hi - 1);
      r = sdaBus;
      tick(1);
      sclOut = 1'b0;
   endtask

   // Eight bits MSB first, no count field, then the ack clock
   task automatic wrByte(input logic [7:0] d, input int hi7, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitIo(d[i], (i == 7) ? hi7 : HALF, r);
      end
      bitIo(1'b1, HALF, ack);
   endtask

   // Read a byte; host ack steps, nack ends; clash bits force contention
   task automatic rdByte(input logic hostAck, input logic [7:0] clash, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitIo(!clash[i], HALF, d[i]);
      end
      bitIo(!hostAck, HALF, r);
   endtask
endmodule
`default_nettype wire

/* File: testbench/smrc_client_tb_top.sv */
/*
 * Self-checking bench for the register client with a host model.
 * Assumes the 10 MHz core clock and a shortened clock-low timeout.
 */
`timescale 1ns/10ps
`default_nettype none

module smrc_client_tb_top;
   import smrc_pkg::*;
   localparam logic [6:0] CADDR = CLIENT_ADDR_DEF;
   logic mclk, srst, sclOut, sdaLow, sdaBus, sdaOut, sdaOe, timeoutDisable, alertPending;
   logic wrValid, wrReady, alertMaskSet, stall, a;
   logic [7:0] regRdAddr, regRdData, wrAddr, wrData, d, p;
   logic [7:0] regs [256];
   logic [7:0] mirror [256];
   logic [15:0] expQ [$];
   logic [15:0] e;
   int seed = 22;
   int failCount = 0;
   int nTests = 0;
   int nTaken = 0;
   int nMask = 0;
   int n0;

   smrc_client #(.CLIENT_ADDR(CADDR), .LOW_TO_CYCLES(200)) uut (
      .mclk(mclk), .srst(srst), .sclIn(sclOut), .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .timeoutDisable(timeoutDisable), .alertPending(alertPending), .regRdAddr(regRdAddr),
      .regRdData(regRdData), .wrValid(wrValid), .wrAddr(wrAddr), .wrData(wrData),
      .wrReady(wrReady), .alertMaskSet(alertMaskSet));
   smrc_host_model host (.mclk(mclk), .sdaBus(sdaBus), .sclOut(sclOut), .sdaLow(sdaLow));

   // Open-drain wire with pull-up, register file read
   assign sdaBus = !sdaLow && (sdaOe ? sdaOut : 1'b1);
   assign regRdData = regs[regRdAddr];

   // Core clock, 100 ns
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic wrapUp();
      $display("comparisons=%0d mismatches=%0d", nTests, failCount);
      if (failCount == 0 && nTests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      nTests++;
      if (got !== exp) begin
         failCount++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask

   // Expected register after i pointer steps, wrapping at 8 bits
   function automatic logic [7:0] stepAddr(input logic [7:0] base, input int i);
      return base + 8'(i);
   endfunction

   // Random stalls by the write consumer
   always @(negedge mclk) begin
      wrReady <= stall ? 1'b0 : (($random(seed) & 3) != 0);
   end

   // Consumer takes words and checks them in order
   always @(posedge mclk) begin
      if (!srst && wrValid === 1'b1 && wrReady) begin
         e = (expQ.size() != 0) ? expQ.pop_front() : 16'hXXXX;
         nTaken++;
         chk8(wrAddr, e[15:8]);
         chk8(wrData, e[7:0]);
         regs[wrAddr] <= wrData;
      end
      if (alertMaskSet === 1'b1) nMask++;
   end

   task automatic drain();
      for (int i = 0; i < 200 && expQ.size() != 0; i++) @(negedge mclk);
      chk8(8'(expQ.size()), 8'h00);
   endtask

   // Address then pointer byte, both acknowledged
   task automatic setPtr(input logic [7:0] q);
      host.start();
      host.wrByte({CADDR, 1'b0}, 4, a);
      chk1(a, 1'b0);
      host.wrByte(q, 4, a);
      chk1(a, 1'b0);
   endtask

   task automatic wrTx(input logic [7:0] q, input int n);
      setPtr(q);
      for (int i = 0; i < n; i++) begin
         d = $random(seed);
         expQ.push_back({stepAddr(q, i), d});
         mirror[stepAddr(q, i)] = d;
         host.wrByte(d, 4, a);
         chk1(a, 1'b0);
      end
      host.stop();
      drain();
   endtask

   task automatic rdTx(input logic [7:0] q, input logic usePtr, input int n);
      if (usePtr) setPtr(q);
      host.start();
      host.wrByte({CADDR, RW_READ}, 4, a);
      chk1(a, 1'b0);
      for (int i = 0; i < n; i++) begin
         host.rdByte(i != n - 1, 8'h00, d);
         chk8(d, mirror[stepAddr(q, i)]);
      end
      host.stop();
   endtask

   // Alert reply read; clash forces contention on chosen bits
   task automatic araTx(input logic [7:0] clash, input logic expAck);
      host.start();
      host.wrByte({ARA_ADDR, RW_READ}, 4, a);
      chk1(a, expAck);
      if (!a) host.rdByte(1'b0, clash, d);
      host.stop();
   endtask

   // Main sequence
   initial begin
      srst = 1'b1;
      timeoutDisable = 1'b1;
      alertPending = 1'b0;
      stall = 1'b0;
      wrReady = 1'b0;
      for (int i = 0; i < 256; i++) begin
         regs[i] = $random(seed);
         mirror[i] = regs[i];
      end
      repeat (3) @(negedge mclk);
      srst = 1'b0;
      repeat (4) @(negedge mclk);
      chk8(regRdAddr, PTR_RESET);
      chk1(sdaOe, 1'b0);
      host.start();
      host.wrByte({CADDR ^ 7'h01, 1'b0}, 4, a);
      chk1(a, 1'b1);
      host.stop();
      p = $random(seed);
      wrTx(p, 1);
      chk8(regRdAddr, p + 8'h01);
      wrTx(8'hFE, 3);
      rdTx(8'hFF, 1'b1, 2);
      for (int k = 0; k < 4; k++) begin
         p = $random(seed);
         n0 = 1 + ($random(seed) & 3);
         wrTx(p, n0);
         rdTx(p, 1'b1, n0);
      end
      p = $random(seed);
      n0 = nTaken;
      setPtr(p);
      host.stop();
      chk8(regRdAddr, p);
      chk8(8'(nTaken), 8'(n0));
      rdTx(p, 1'b0, 1);
      rdTx(p, 1'b0, 1);
      stall = 1'b1;
      setPtr(p);
      for (int i = 0; i < 3; i++) begin
         d = $random(seed);
         if (i < 2) expQ.push_back({p + 8'(i), d});
         if (i < 2) mirror[p + 8'(i)] = d;
         host.wrByte(d, 4, a);
         chk1(a, i == 2);
      end
      host.stop();
      stall = 1'b0;
      drain();
      araTx(8'h00, 1'b1);
      alertPending = 1'b1;
      n0 = nMask;
      araTx(8'h00, 1'b0);
      chk8(d, {CADDR, ARA_LSB});
      chk8(8'(nMask), 8'(n0 + 1));
      araTx(8'h40, 1'b0);
      chk8(8'(nMask), 8'(n0 + 1));
      alertPending = 1'b0;
      for (int t = 1; t >= 0; t--) begin
         timeoutDisable = t[0];
         host.start();
         host.wrByte({CADDR, 1'b0}, 4, a);
         host.tick(250);
         host.wrByte(p, 4, a);
         chk1(a, !t[0]);
         host.stop();
      end
      timeoutDisable = 1'b1;
      host.start();
      host.wrByte({CADDR, 1'b0}, 4, a);
      host.wrByte(8'h80 | p, 1600, a);
      chk1(a, 1'b1);
      host.stop();
      rdTx(p, 1'b1, 1);
      wrapUp();
   end

   // Hang guard
   initial begin
      repeat (90000) @(posedge mclk);
      failCount++;
      wrapUp();
   end
endmodule
`default_nettype wire
